// ### core/clk_ctrl_regs.svh
// Register offsets, field positions, reset values and counts of the clock control block
`ifndef CLK_CTRL_REGS_SVH
`define CLK_CTRL_REGS_SVH

`define OSC_CTRL_OFS 4'h0
`define OSC_TUNE_OFS 4'h4
`define CLK_STAT_OFS 4'h8

`define CTRL_IDLE_BIT 7
`define CTRL_FREQ_LSB 4
`define CTRL_STARTUP_BIT 3
`define CTRL_FASTOK_BIT 2
`define TUNE_LFSRC_BIT 7
`define TUNE_MULT_BIT 6

`define FREQ_RST 3'h6
`define FREQ_SLOW 3'h0
`define TUNE_RST 8'h00

`define SCS_INTERNAL 2'h3
`define SCS_PRIMARY 2'h2
`define SCS_SECONDARY 2'h1
`define SCS_DEFAULT 2'h0

`define MODE_EXT_MULT 3'h7
`define MODE_EXT 3'h6
`define MODE_XTAL_MULT 3'h5
`define MODE_XTAL 3'h4
`define MODE_INT_MULT_CLKOUT 3'h3
`define MODE_INT_CLKOUT 3'h2
`define MODE_INT_MULT_IO 3'h1
`define MODE_INT_IO 3'h0

`define SW_OLD_TICKS 2'h2
`define SW_NEW_TICKS 2'h3
`define MULT_FACTOR_ON 3'h4
`define MULT_FACTOR_OFF 3'h1

`endif

// ### core/clk_ctrl_pkg.sv
// Types shared by the clock control block
package clk_ctrl_pkg;
	typedef enum logic [1:0] {
		SRC_SLOW_RC,
		SRC_PRIMARY,
		SRC_SECONDARY,
		SRC_INTERNAL
	} src_type;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_WAIT_STABLE,
		SEQ_OLD,
		SEQ_NEW
	} seq_state_type;
endpackage

// ### core/clk_switch_if.sv
// Handshake between the clock control core and the switch sequencer
`timescale 1ns/1ns
interface clk_switch_if;
	logic start;
	logic old_tick;
	logic new_tick;
	logic new_stable;
	logic hold;
	logic done;
	logic busy;

	modport ctrl (output start, output old_tick, output new_tick, output new_stable,
		input hold, input done, input busy);
	modport seq (input start, input old_tick, input new_tick, input new_stable,
		output hold, output done, output busy);
endinterface

// ### core/clk_switch_seq.sv
// Glitch-free handover sequencer: wait stable, two old ticks, three new ticks
`timescale 1ns/1ns
`include "clk_ctrl_regs.svh"
module clk_switch_seq (
	input wire logic clk,
	input wire logic rst,
	clk_switch_if.seq sw
);
	typedef struct packed {
		clk_ctrl_pkg::seq_state_type state;
		logic [1:0] cnt;
		logic hold;
		logic done;
	} seq_reg_type;

	seq_reg_type q_ff;
	seq_reg_type nxt_q;

	always_comb begin
		nxt_q = q_ff;
		nxt_q.done = 1'b0;
		unique case (q_ff.state)
			clk_ctrl_pkg::SEQ_IDLE: begin
				if (sw.start) begin
					nxt_q.state = clk_ctrl_pkg::SEQ_WAIT_STABLE;
				end
			end
			clk_ctrl_pkg::SEQ_WAIT_STABLE: begin
				// Stay on the old source until the new one is stable
				if (sw.new_stable) begin
					nxt_q.state = clk_ctrl_pkg::SEQ_OLD;
					nxt_q.hold = 1'b1;
					nxt_q.cnt = 2'h0;
				end
			end
			clk_ctrl_pkg::SEQ_OLD: begin
				// Pause spans two old-source cycles
				if (sw.old_tick) begin
					nxt_q.cnt = q_ff.cnt + 2'h1;
					if (q_ff.cnt == `SW_OLD_TICKS - 2'h1) begin
						nxt_q.state = clk_ctrl_pkg::SEQ_NEW;
						nxt_q.cnt = 2'h0;
					end
				end
			end
			clk_ctrl_pkg::SEQ_NEW: begin
				// Then three new-source cycles before release
				if (sw.new_tick) begin
					nxt_q.cnt = q_ff.cnt + 2'h1;
					if (q_ff.cnt == `SW_NEW_TICKS - 2'h1) begin
						nxt_q.state = clk_ctrl_pkg::SEQ_IDLE;
						nxt_q.hold = 1'b0;
						nxt_q.done = 1'b1;
						nxt_q.cnt = 2'h0;
					end
				end
			end
		endcase
		if (rst) begin
			nxt_q = '0;
		end
	end

	always_ff @(posedge clk) begin
		q_ff <= nxt_q;
	end

	assign sw.hold = q_ff.hold;
	assign sw.done = q_ff.done;
	assign sw.busy = (q_ff.state != clk_ctrl_pkg::SEQ_IDLE);

	a_hold_after_stable: assert property (@(posedge clk) disable iff (rst)
		$rose(q_ff.hold) |-> $past(sw.new_stable))
		else $error("Clock held before the new source was stable");
	a_done_releases: assert property (@(posedge clk) disable iff (rst)
		q_ff.done |-> !q_ff.hold && $past(q_ff.hold))
		else $error("Handover ended without a pause");
	c_handover: cover property (@(posedge clk) disable iff (rst) q_ff.done);
endmodule

// ### core/clk_source_ctrl.sv
// Clock source control: mode decode, source switching, internal RC and multiplier control
`timescale 1ns/1ns
`include "clk_ctrl_regs.svh"
module clk_source_ctrl (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic [2:0] CFG_OSC_MODE,
	input wire logic CFG_TWO_SPEED,
	input wire logic CFG_LOADED,
	input wire logic OSC_ALT_MAP,
	input wire logic SEC_OSC_ENABLE,
	input wire logic SLEEP_EXEC,
	input wire logic PRI_READY,
	input wire logic FAST_RC_READY,
	input wire logic SEC_READY,
	input wire logic SLOW_TICK,
	input wire logic PRI_TICK,
	input wire logic SEC_TICK,
	input wire logic INT_TICK,
	output logic [1:0] ACTIVE_SRC,
	output logic CLK_HOLD,
	output logic [2:0] INT_FREQ_SEL,
	output logic [5:0] FAST_RC_TRIM,
	output logic LF_FROM_FAST,
	output logic FAST_RC_EN,
	output logic SLOW_RC_EN,
	output logic PLL_ON,
	output logic [2:0] MULT_FACTOR,
	output logic CLKOUT_EN,
	output logic OSC_IN_IS_IO,
	output logic OSC_OUT_IS_IO,
	output logic IDLE_ENTER,
	output logic SLEEP_ENTER
);
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic idle_sel;
		logic [2:0] freq;
		logic [1:0] scs;
		logic lf_src;
		logic mult_en;
		logic [5:0] trim;
		logic startup_done;
		clk_ctrl_pkg::src_type active;
		clk_ctrl_pkg::src_type target;
		logic hold;
		logic [3:0] tick_s1;
		logic [3:0] tick_s2;
		logic [3:0] tick_s3;
		logic [2:0] rdy_s1;
		logic [2:0] rdy_s2;
		logic pll_on;
		logic [2:0] mult;
		logic fast_en;
		logic slow_en;
		logic clkout_en;
		logic in_io;
		logic out_io;
		logic idle_pulse;
		logic sleep_pulse;
	} ctrl_reg_type;

	ctrl_reg_type q_ff;
	ctrl_reg_type nxt_q;
	clk_switch_if sw ();

	logic [3:0] tick_edge;
	logic pri_rdy;
	logic fast_rdy;
	logic sec_rdy;
	logic int_mode;
	logic bus_req;
	logic ctrl_ok;
	logic [7:0] ctrl_rd;
	clk_ctrl_pkg::src_type want;

	clk_switch_seq u_seq (
		.clk(SYS_CLK),
		.rst(RST),
		.sw(sw)
	);

	assign tick_edge = q_ff.tick_s2 & ~q_ff.tick_s3;
	assign pri_rdy = q_ff.rdy_s2[0];
	assign fast_rdy = q_ff.rdy_s2[1];
	assign sec_rdy = q_ff.rdy_s2[2];
	// Configuration codes below the crystal modes are the internal-block variants
	assign int_mode = (CFG_OSC_MODE < `MODE_XTAL);

	function automatic logic src_stable(clk_ctrl_pkg::src_type s);
		logic r;
		r = 1'b1;
		unique case (s)
			clk_ctrl_pkg::SRC_SLOW_RC: r = 1'b1;
			clk_ctrl_pkg::SRC_PRIMARY: r = int_mode ? fast_rdy : pri_rdy;
			clk_ctrl_pkg::SRC_SECONDARY: r = sec_rdy;
			clk_ctrl_pkg::SRC_INTERNAL: r = (q_ff.freq == `FREQ_SLOW && !q_ff.lf_src) ||
				fast_rdy;
		endcase
		return r;
	endfunction

	// Requested source from the select field
	always_comb begin
		unique case (q_ff.scs)
			`SCS_INTERNAL: want = clk_ctrl_pkg::SRC_INTERNAL;
			`SCS_SECONDARY: want = SEC_OSC_ENABLE ? clk_ctrl_pkg::SRC_SECONDARY :
				q_ff.active;
			default: want = clk_ctrl_pkg::SRC_PRIMARY;
		endcase
	end

	// Switch starts when the wanted source differs from the active one and no handover is running, after configuration load
	assign sw.start = CFG_LOADED && !sw.busy && !sw.done && (want != q_ff.active);
	assign sw.old_tick = tick_edge[q_ff.active];
	assign sw.new_tick = tick_edge[q_ff.target];
	assign sw.new_stable = src_stable(q_ff.target);

	assign bus_req = WB_CYC_I && WB_STB_I && !q_ff.ack;
	assign ctrl_ok = !OSC_ALT_MAP;
	assign ctrl_rd = {q_ff.idle_sel, q_ff.freq, q_ff.startup_done, fast_rdy, q_ff.scs};

	always_comb begin
		nxt_q = q_ff;
		nxt_q.ack = 1'b0;
		nxt_q.idle_pulse = 1'b0;
		nxt_q.sleep_pulse = 1'b0;
		nxt_q.tick_s1 = {INT_TICK, SEC_TICK, PRI_TICK, SLOW_TICK};
		nxt_q.tick_s2 = q_ff.tick_s1;
		nxt_q.tick_s3 = q_ff.tick_s2;
		nxt_q.rdy_s1 = {SEC_READY, FAST_RC_READY, PRI_READY};
		nxt_q.rdy_s2 = q_ff.rdy_s1;

		if (bus_req) begin
			nxt_q.ack = 1'b1;
			nxt_q.rdata = 32'h0;
			unique case (WB_ADR_I)
				`OSC_CTRL_OFS: begin
					if (ctrl_ok) begin
						nxt_q.rdata[7:0] = ctrl_rd;
					end
					if (ctrl_ok && WB_WE_I && WB_SEL_I[0]) begin
						nxt_q.idle_sel = WB_DAT_I[`CTRL_IDLE_BIT];
						// Frequency applies at once to the internal block
						nxt_q.freq = WB_DAT_I[`CTRL_FREQ_LSB +: 3];
						nxt_q.scs = WB_DAT_I[1:0];
					end
				end
				`OSC_TUNE_OFS: begin
					nxt_q.rdata[7:0] = {q_ff.lf_src, q_ff.mult_en, q_ff.trim};
					if (WB_WE_I && WB_SEL_I[0]) begin
						nxt_q.lf_src = WB_DAT_I[`TUNE_LFSRC_BIT];
						nxt_q.mult_en = WB_DAT_I[`TUNE_MULT_BIT];
						nxt_q.trim = WB_DAT_I[5:0];
					end
				end
				`CLK_STAT_OFS: begin
					nxt_q.rdata[7:0] = {1'b0, sw.busy, q_ff.hold, q_ff.pll_on,
						(q_ff.active == clk_ctrl_pkg::SRC_SECONDARY), CFG_LOADED,
						q_ff.active};
				end
				default: begin
					nxt_q.rdata = 32'h0;
				end
			endcase
		end

		if (sw.start) begin
			nxt_q.target = want;
		end
		if (sw.done) begin
			nxt_q.active = q_ff.target;
		end
		nxt_q.hold = sw.hold;

		// Start-up bit only with primary running or, during reset, with two-speed start-up off, so never with secondary
		nxt_q.startup_done = (nxt_q.active == clk_ctrl_pkg::SRC_PRIMARY) && pri_rdy;

		if (SLEEP_EXEC) begin
			nxt_q.idle_pulse = q_ff.idle_sel;
			nxt_q.sleep_pulse = !q_ff.idle_sel;
		end

		// Multiplier only in multiplied modes with enable set
		nxt_q.pll_on = 1'b0;
		if (q_ff.mult_en && q_ff.active == clk_ctrl_pkg::SRC_PRIMARY &&
			(CFG_OSC_MODE == `MODE_EXT_MULT || CFG_OSC_MODE == `MODE_XTAL_MULT)) begin
			nxt_q.pll_on = 1'b1;
		end
		if (q_ff.mult_en && (CFG_OSC_MODE == `MODE_INT_MULT_CLKOUT ||
			CFG_OSC_MODE == `MODE_INT_MULT_IO) &&
			(q_ff.active == clk_ctrl_pkg::SRC_PRIMARY ||
			q_ff.active == clk_ctrl_pkg::SRC_INTERNAL)) begin
			nxt_q.pll_on = 1'b1;
		end
		nxt_q.mult = nxt_q.pll_on ? `MULT_FACTOR_ON : `MULT_FACTOR_OFF;

		nxt_q.fast_en = (q_ff.freq != `FREQ_SLOW) || q_ff.lf_src;
		nxt_q.slow_en = 1'b1;
		nxt_q.clkout_en = CFG_LOADED && (CFG_OSC_MODE == `MODE_EXT ||
			CFG_OSC_MODE == `MODE_INT_CLKOUT || CFG_OSC_MODE == `MODE_INT_MULT_CLKOUT);
		nxt_q.in_io = CFG_LOADED && int_mode;
		nxt_q.out_io = CFG_LOADED && (CFG_OSC_MODE == `MODE_INT_IO ||
			CFG_OSC_MODE == `MODE_INT_MULT_IO);

		if (RST) begin
			nxt_q = '0;
			nxt_q.freq = `FREQ_RST;
			nxt_q.scs = `SCS_DEFAULT;
			{nxt_q.lf_src, nxt_q.mult_en, nxt_q.trim} = `TUNE_RST;
			nxt_q.startup_done = !CFG_TWO_SPEED;
			nxt_q.active = clk_ctrl_pkg::SRC_SLOW_RC;
			nxt_q.target = clk_ctrl_pkg::SRC_SLOW_RC;
			nxt_q.mult = `MULT_FACTOR_OFF;
			nxt_q.slow_en = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		q_ff <= nxt_q;
	end

	assign WB_DAT_O = q_ff.rdata;
	assign WB_ACK_O = q_ff.ack;
	assign ACTIVE_SRC = q_ff.active;
	assign CLK_HOLD = q_ff.hold;
	assign INT_FREQ_SEL = q_ff.freq;
	assign FAST_RC_TRIM = q_ff.trim;
	assign LF_FROM_FAST = q_ff.lf_src;
	assign FAST_RC_EN = q_ff.fast_en;
	assign SLOW_RC_EN = q_ff.slow_en;
	assign PLL_ON = q_ff.pll_on;
	assign MULT_FACTOR = q_ff.mult;
	assign CLKOUT_EN = q_ff.clkout_en;
	assign OSC_IN_IS_IO = q_ff.in_io;
	assign OSC_OUT_IS_IO = q_ff.out_io;
	assign IDLE_ENTER = q_ff.idle_pulse;
	assign SLEEP_ENTER = q_ff.sleep_pulse;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("Acknowledge held longer than one cycle");
	a_reset_select: assert property ($fell(RST) |-> q_ff.scs == `SCS_DEFAULT)
		else $error("Select field not cleared by reset");
	a_sleep_idle: assert property (SLEEP_EXEC && q_ff.idle_sel |=> IDLE_ENTER && !SLEEP_ENTER)
		else $error("Idle not entered on sleep with idle select");
	a_sleep_full: assert property (SLEEP_EXEC && !q_ff.idle_sel |=> SLEEP_ENTER && !IDLE_ENTER)
		else $error("Full sleep not entered");
	a_pll_gate: assert property (PLL_ON |-> $past(q_ff.mult_en) &&
		$past(CFG_OSC_MODE) != `MODE_EXT && $past(CFG_OSC_MODE) != `MODE_XTAL)
		else $error("Multiplier on without enable");
	a_pll_factor: assert property (PLL_ON |-> MULT_FACTOR == 3'h4)
		else $error("Multiplier factor not four");
	a_io_no_clkout: assert property (OSC_OUT_IS_IO |-> !CLKOUT_EN)
		else $error("Clock out driven in I/O mode");
	a_status_excl: assert property (!(q_ff.startup_done &&
		ACTIVE_SRC == clk_ctrl_pkg::SRC_SECONDARY))
		else $error("Start-up and secondary flags both set");
	a_sec_blocked: assert property (!SEC_OSC_ENABLE |->
		!(sw.start && want == clk_ctrl_pkg::SRC_SECONDARY))
		else $error("Secondary selected while disabled");
	a_boot_slow: assert property (!CFG_LOADED |-> !sw.start)
		else $error("Switch before configuration load");

	c_switch_done: cover property (sw.done);
	c_pll_on: cover property ($rose(PLL_ON));
	c_idle_enter: cover property (IDLE_ENTER);
	c_to_secondary: cover property (sw.done && q_ff.target == clk_ctrl_pkg::SRC_SECONDARY);
endmodule

// ### verification/osc_source_model.sv
// Behavioural oscillator on the far side: free-running tick and a ready flag after start-up
`timescale 1ns/1ns
module osc_source_model #(
	parameter int HALF = 3,
	parameter int START = 10
) (
	input wire logic clk,
	input wire logic run,
	output logic tick,
	output logic ready
);
	int ph;
	int up;
	initial begin
		tick = 1'b0;
		ready = 1'b0;
		ph = 0;
		up = 0;
	end
	// Stopped oscillator gives no rising edges and loses its ready flag
	always @(posedge clk) begin
		if (!run) begin
			tick <= 1'b0;
			ready <= 1'b0;
			ph <= 0;
			up <= 0;
		end else begin
			ph <= (ph == HALF - 1) ? 0 : ph + 1;
			if (ph == HALF - 1) begin
				tick <= ~tick;
			end
			if (up < START) begin
				up <= up + 1;
			end
			ready <= (up >= START);
		end
	end
endmodule

// ### verification/test_clk_source_ctrl.sv
// Register-level testbench of the clock source control block
`timescale 1ns/1ns
module test_clk_source_ctrl;
	logic clk, rst, cyc, stb, we, two_sp, loaded, alt, sec_en, sleep;
	logic [3:0] adr, sel;
	logic [31:0] dat_i, dat_o, q;
	logic [2:0] mode, freq, mult;
	logic [1:0] act;
	logic [5:0] trim;
	logic ack, hold, lf, fast_en, slow_en, pll, clkout, in_io, out_io, idle_e, sleep_e;
	logic pri_rdy, fast_rdy, sec_rdy, t_slow, t_pri, t_sec, t_int, pri_run;
	localparam int SEC_HALF = 5;
	localparam int SEC_START = 120;
	localparam int INT_HALF = 2;
	localparam int INT_START = 8;
	localparam int SLOW_HALF = 4;
	localparam int SLOW_START = 2;
	int miscompares = 0;
	int checks_done = 0;

	clk_source_ctrl clk_source_ctrl_i (.SYS_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .CFG_OSC_MODE(mode), .CFG_TWO_SPEED(two_sp), .CFG_LOADED(loaded),
		.OSC_ALT_MAP(alt), .SEC_OSC_ENABLE(sec_en), .SLEEP_EXEC(sleep), .PRI_READY(pri_rdy),
		.FAST_RC_READY(fast_rdy), .SEC_READY(sec_rdy), .SLOW_TICK(t_slow), .PRI_TICK(t_pri),
		.SEC_TICK(t_sec), .INT_TICK(t_int), .ACTIVE_SRC(act), .CLK_HOLD(hold),
		.INT_FREQ_SEL(freq), .FAST_RC_TRIM(trim), .LF_FROM_FAST(lf), .FAST_RC_EN(fast_en),
		.SLOW_RC_EN(slow_en), .PLL_ON(pll), .MULT_FACTOR(mult), .CLKOUT_EN(clkout),
		.OSC_IN_IS_IO(in_io), .OSC_OUT_IS_IO(out_io), .IDLE_ENTER(idle_e),
		.SLEEP_ENTER(sleep_e));
	osc_source_model pri_m (.clk(clk), .run(pri_run), .tick(t_pri), .ready(pri_rdy));
	osc_source_model #(.HALF(SEC_HALF), .START(SEC_START)) sec_m (.clk(clk), .run(sec_en),
		.tick(t_sec), .ready(sec_rdy));
	osc_source_model #(.HALF(INT_HALF), .START(INT_START)) int_m (.clk(clk), .run(fast_en),
		.tick(t_int), .ready(fast_rdy));
	osc_source_model #(.HALF(SLOW_HALF), .START(SLOW_START)) slow_m (.clk(clk), .run(slow_en),
		.tick(t_slow), .ready());

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic single cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50) begin
			chk_val(ack, 1'b1);
			stop_test();
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
		repeat (2) @(posedge clk);
	endtask

	task automatic chk_rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk_val(q & {24'h0, m}, {24'h0, e});
	endtask

	task automatic wait_src(input logic [1:0] s);
		int n;
		logic seen;
		n = 0;
		seen = 1'b0;
		while (act !== s && n < 400) begin
			@(posedge clk);
			n++;
			if (hold === 1'b1) begin
				seen = 1'b1;
			end
		end
		chk_val({act, seen}, {s, 1'b1});
		if (n >= 400) begin
			stop_test();
		end
	endtask

	task automatic slp(input logic ei, input logic es);
		logic [1:0] ci, cs;
		ci = 2'h0;
		cs = 2'h0;
		@(posedge clk);
		sleep <= 1'b1;
		@(posedge clk);
		sleep <= 1'b0;
		repeat (3) begin
			@(posedge clk);
			ci = ci + idle_e;
			cs = cs + sleep_e;
		end
		chk_val({ci, cs}, {1'b0, ei, 1'b0, es});
	endtask

	task automatic tend(input string s);
		$display("%s finished", s);
	endtask

	initial begin
		rst = 1'b1;
		pri_run = 1'b1;
		{cyc, stb, we, two_sp, loaded, alt, sec_en, sleep} = 8'h00;
		adr = 4'h0;
		sel = 4'hf;
		dat_i = 32'h0;
		mode = 3'h4;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk_val({act, slow_en, freq, mult}, {2'h0, 1'b1, 3'h6, 3'h1});
		chk_rd(4'h0, 8'hf3, 8'h60);
		chk_rd(4'h4, 8'hff, 8'h00);
		chk_rd(4'hc, 8'hff, 8'h00);
		tend("reset");
		loaded <= 1'b1;
		wait_src(2'h1);
		chk_rd(4'h0, 8'h08, 8'h08);
		chk_rd(4'h8, 8'h07, 8'h05);
		tend("config load");
		wr(4'h4, 8'h40);
		for (int m = 0; m < 8; m++) begin
			mode <= m[2:0];
			repeat (4) @(posedge clk);
			chk_val({clkout, in_io, out_io, pll, mult}, {m == 6 || m == 3 || m == 2, m < 4, m < 2,
				m[0], m[0] ? 3'h4 : 3'h1});
		end
		wr(4'h4, 8'h00);
		chk_val(pll, 1'b0);
		mode <= 3'h4;
		tend("modes");
		for (int f = 0; f < 8; f++) begin
			wr(4'h0, {1'b0, f[2:0], 4'h2});
			chk_val({freq, fast_en}, {f[2:0], f != 0});
		end
		wr(4'h4, 8'h9f);
		chk_val({trim, lf, fast_en}, {6'h1f, 1'b1, 1'b1});
		wr(4'h4, 8'h20);
		chk_rd(4'h4, 8'hff, 8'h20);
		wr(4'h0, 8'h62);
		tend("frequency");
		wr(4'h0, 8'h63);
		wait_src(2'h3);
		chk_rd(4'h0, 8'h08, 8'h00);
		wr(4'h0, 8'h73);
		chk_val(freq, 3'h7);
		tend("internal switch");
		wr(4'h0, 8'h71);
		repeat (40) @(posedge clk);
		chk_val(act, 2'h3);
		sec_en <= 1'b1;
		wr(4'h0, 8'h71);
		repeat (20) @(posedge clk);
		chk_val({act, hold}, {2'h3, 1'b0});
		wait_src(2'h2);
		chk_rd(4'h8, 8'h0b, 8'h0a);
		chk_rd(4'h0, 8'h08, 8'h00);
		tend("secondary switch");
		wr(4'h0, 8'hf1);
		slp(1'b1, 1'b0);
		wr(4'h0, 8'h71);
		slp(1'b0, 1'b1);
		tend("sleep");
		alt <= 1'b1;
		chk_rd(4'h0, 8'hff, 8'h00);
		wr(4'h0, 8'h03);
		alt <= 1'b0;
		chk_rd(4'h0, 8'h03, 8'h01);
		tend("shared address");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk_val(act, 2'h0);
		chk_rd(4'h0, 8'h03, 8'h00);
		wait_src(2'h1);
		tend("second reset");
		stop_test();
	end
endmodule
